/* src/tis_scheduler.sv */
// Timed injection scheduler: calendar, injection counter, table update engine
// Summary of operation
// RQ1: Default setup walks entries 0..2047 then wraps.
// RQ2: Each entry serviced within four clock cycles.
// RQ3: Software keeps visits faster than entry ticks.
// RQ4: Four calendar slots, each with first/last pointers.
// RQ5: Slot services its count, then next slot.
// RQ6: Calendar length sets number of slots cycled.
// RQ7: Init bit restarts at slot zero, self-clears.
// RQ8: Software initialises calendar before global enable.
// RQ9: Global counter counts injections of counting entries.
// RQ10: Start control launches pass from first address.
// RQ11: Pass steps upward, stops before end address.
// RQ12: Group tag AND mask equals either compare.
// RQ13: Enable bit gates the group criterion.
// RQ14: Port criterion applies only when enabled.
// RQ15: Queue criterion applies only when enabled.
// RQ16: Matching entries take commanded timer enable.
// RQ17: Matching entries take commanded destination port.
// RQ18: Matching entries take commanded destination queue.
// RQ19: Only matching entries are written back.
// RQ20: Pass suppresses injections of matching in-range entries.
// RQ21: Tick change decrements; zero injects and reloads.
// RQ22: Group, port and queue criteria are ANDed.
// RQ23: Start bit reads busy, clears when done.
module tis_scheduler (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [tis_pkg::BUS_AW-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [7:0] tickToggle,
    output logic injValid,
    output logic [tis_pkg::AW-1:0] injEntry,
    output logic [tis_pkg::PORT_W-1:0] injPort,
    output logic [tis_pkg::QUEUE_W-1:0] injQueue
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic ctrlEna;
    logic ctrlInit;
    logic [1:0] calLen;
    logic [tis_pkg::AW-1:0] slotFirst [tis_pkg::SLOTS];
    logic [tis_pkg::AW-1:0] slotLast [tis_pkg::SLOTS];
    logic [tis_pkg::SCNT_W-1:0] slotCount [tis_pkg::SLOTS];
    logic [tis_pkg::AW-1:0] cursor [tis_pkg::SLOTS];
    logic [1:0] slot;
    logic [tis_pkg::SCNT_W-1:0] served;
    logic [tis_pkg::ICNT_W-1:0] injCount;
    logic [7:0] tupeMisc;
    logic tupeBusy;
    logic [tis_pkg::AW-1:0] tupeAddr;
    logic [tis_pkg::AW-1:0] tupeStart;
    logic [tis_pkg::AW-1:0] tupeEnd;
    logic [tis_pkg::PORT_W-1:0] critPort;
    logic [tis_pkg::QUEUE_W-1:0] critQueue;
    logic [tis_pkg::TAG_W-1:0] critMask;
    logic [tis_pkg::TAG_W-1:0] critVal0;
    logic [tis_pkg::TAG_W-1:0] critVal1;
    logic [tis_pkg::PORT_W-1:0] setPort;
    logic [tis_pkg::QUEUE_W-1:0] setQueue;
    logic [tis_pkg::AW-1:0] tblIdx;
    // Injector table held in flip-flops, one element per entry
    logic timerEna [tis_pkg::ENTRIES];
    logic countEna [tis_pkg::ENTRIES];
    logic tickSeen [tis_pkg::ENTRIES];
    logic [2:0] tickSel [tis_pkg::ENTRIES];
    logic [tis_pkg::PORT_W-1:0] destPort [tis_pkg::ENTRIES];
    logic [tis_pkg::QUEUE_W-1:0] destQueue [tis_pkg::ENTRIES];
    logic [tis_pkg::TAG_W-1:0] groupTag [tis_pkg::ENTRIES];
    logic [tis_pkg::LEN_W-1:0] interval [tis_pkg::ENTRIES];
    logic [tis_pkg::LEN_W-1:0] remaining [tis_pkg::ENTRIES];

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire [3:0] page = regAddr[7:4];
    wire [1:0] pageSlot = regAddr[3:2];
    wire wrCtrl = regWr && regAddr == tis_pkg::OFF_CTRL;
    wire wrMisc = regWr && regAddr == tis_pkg::OFF_TUPE_MISC;
    wire wrTupeAddr = regWr && regAddr == tis_pkg::OFF_TUPE_ADDR;
    wire wrCrit1 = regWr && regAddr == tis_pkg::OFF_CRIT1;
    wire wrCrit2 = regWr && regAddr == tis_pkg::OFF_CRIT2;
    wire wrCrit3 = regWr && regAddr == tis_pkg::OFF_CRIT3;
    wire wrCmd1 = regWr && regAddr == tis_pkg::OFF_CMD1;
    wire wrIdx = regWr && regAddr == tis_pkg::OFF_TBL_IDX;
    wire wrD0 = regWr && regAddr == tis_pkg::OFF_TBL_D0;
    wire wrD1 = regWr && regAddr == tis_pkg::OFF_TBL_D1;
    wire wrPtrs = regWr && page == tis_pkg::PAGE_SLOT_PTRS;
    wire wrCnt = regWr && page == tis_pkg::PAGE_CAL_SLOT_SERVICE_COUNT;
    wire startReq = wrMisc && regWdata[tis_pkg::TM_START];

    // ----------------------------------------------------------------
    // Read multiplexer; unmapped offsets read zero
    // ----------------------------------------------------------------
    wire [31:0] rdCtrl = {26'h0, calLen, 2'h0, ctrlInit, ctrlEna};
    wire [31:0] rdMisc = {24'h0, tupeMisc[7:1], tupeBusy}; // RQ23
    wire [31:0] rdAddr = {5'h0, tupeEnd, 5'h0, tupeStart};
    wire [31:0] rdCrit1 = {16'h0, critQueue, 4'h0, critPort};
    wire [31:0] rdCmd1 = {16'h0, setQueue, 4'h0, setPort};
    wire [31:0] rdD0 = {groupTag[tblIdx], destQueue[tblIdx], 4'h0, destPort[tblIdx],
        3'h0, tickSel[tblIdx], countEna[tblIdx], timerEna[tblIdx]};
    wire [31:0] rdD1 = {16'h0, remaining[tblIdx], interval[tblIdx]};
    wire [31:0] rdPtrs = {5'h0, slotLast[pageSlot], 5'h0, slotFirst[pageSlot]};
    wire [31:0] rdCnt = {20'h0, slotCount[pageSlot]};
    wire [31:0] readMux =
        regAddr == tis_pkg::OFF_CTRL ? rdCtrl :
        regAddr == tis_pkg::OFF_INJ_CNT ? injCount :
        regAddr == tis_pkg::OFF_TUPE_MISC ? rdMisc :
        regAddr == tis_pkg::OFF_TUPE_ADDR ? rdAddr :
        regAddr == tis_pkg::OFF_CRIT1 ? rdCrit1 :
        regAddr == tis_pkg::OFF_CRIT2 ? {24'h0, critMask} :
        regAddr == tis_pkg::OFF_CRIT3 ? {16'h0, critVal1, critVal0} :
        regAddr == tis_pkg::OFF_CMD1 ? rdCmd1 :
        regAddr == tis_pkg::OFF_TBL_IDX ? {21'h0, tblIdx} :
        regAddr == tis_pkg::OFF_TBL_D0 ? rdD0 :
        regAddr == tis_pkg::OFF_TBL_D1 ? rdD1 :
        page == tis_pkg::PAGE_SLOT_PTRS ? rdPtrs :
        page == tis_pkg::PAGE_CAL_SLOT_SERVICE_COUNT ? rdCnt : 32'h0;

    // ----------------------------------------------------------------
    // Calendar stepping
    // ----------------------------------------------------------------
    // One entry per cycle, well inside the four-cycle service budget
    wire svcRun = ctrlEna && !ctrlInit; // RQ8
    wire [tis_pkg::AW-1:0] svcIdx = cursor[slot];
    wire atSlotLast = svcIdx == slotLast[slot];
    wire [tis_pkg::AW-1:0] next_cursor = atSlotLast ? slotFirst[slot] : svcIdx + 11'h001; // RQ1
    wire [tis_pkg::SCNT_W-1:0] servedInc = served + 12'h001;
    wire slotDone = servedInc >= slotCount[slot]; // RQ5
    wire [1:0] next_slot = (slot == calLen) ? 2'h0 : slot + 2'h1; // RQ6

    // Cursors remember where each section left off; init rewinds them all
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            slot <= 2'h0;
            served <= '0;
            for (int s = 0; s < tis_pkg::SLOTS; s++)
                cursor[s] <= tis_pkg::SLOT_FIRST_RST;
        end
        else if (ctrlInit)
        begin
            slot <= 2'h0; // RQ7
            served <= '0;
            for (int s = 0; s < tis_pkg::SLOTS; s++)
                cursor[s] <= slotFirst[s];
        end
        else if (svcRun)
        begin
            cursor[slot] <= next_cursor; // RQ2 RQ4
            served <= slotDone ? '0 : servedInc;
            slot <= slotDone ? next_slot : slot;
        end
    end

    // ----------------------------------------------------------------
    // Entry service: tick change, countdown, injection
    // ----------------------------------------------------------------
    // Match criteria, bit 0 for the serviced entry, bit 1 for the pass entry;
    // nets rather than a function so a start write's new criteria are seen at once
    wire [1:0] lookMatch;
    for (genvar k = 0; k < 2; k++)
    begin : g_match
        wire [tis_pkg::AW-1:0] idx = (k == 0) ? svcIdx : tupeAddr;
        wire [tis_pkg::TAG_W-1:0] masked = groupTag[idx] & critMask;
        wire grpOk = !tupeMisc[tis_pkg::TM_GRP_ENA]
            || masked == critVal0 || masked == critVal1; // RQ12 RQ13
        wire portOk = !tupeMisc[tis_pkg::TM_PORT_ENA] || destPort[idx] == critPort; // RQ14
        wire queueOk = !tupeMisc[tis_pkg::TM_QUEUE_ENA] || destQueue[idx] == critQueue; // RQ15
        assign lookMatch[k] = grpOk && portOk && queueOk; // RQ22
    end

    wire tickNow = tickToggle[tickSel[svcIdx]];
    wire tickChg = tickNow != tickSeen[svcIdx];
    wire oneShot = interval[svcIdx] == tis_pkg::LEN_ONESHOT;
    wire armed = timerEna[svcIdx] && interval[svcIdx] != '0;
    wire expire = tickChg && remaining[svcIdx] <= 8'h01;
    wire fire = svcRun && armed && (oneShot || expire); // RQ21
    wire inTupeRange = svcIdx >= tupeStart && svcIdx < tupeEnd;
    wire blocked = tupeBusy && inTupeRange && lookMatch[0]; // RQ20
    wire inject = fire && !blocked;
    // A blocked expiry holds the count at one so it fires after the pass
    wire [tis_pkg::LEN_W-1:0] next_remaining =
        fire ? (blocked ? 8'h01 : interval[svcIdx]) :
        (tickChg && remaining[svcIdx] != '0) ? remaining[svcIdx] - 8'h01 :
        remaining[svcIdx]; // RQ21

    // ----------------------------------------------------------------
    // Update pass stepping
    // ----------------------------------------------------------------
    wire tupeHit = tupeBusy && lookMatch[1]; // RQ19
    wire [tis_pkg::AW-1:0] tupeNext = tupeAddr + 11'h001; // RQ11
    wire tupeLast = tupeNext >= tupeEnd; // RQ11

    // ----------------------------------------------------------------
    // Table writes; software lands last so it wins on a shared field
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int e = 0; e < tis_pkg::ENTRIES; e++)
            begin
                timerEna[e] <= 1'b0;
                countEna[e] <= 1'b0;
                tickSeen[e] <= 1'b0;
                tickSel[e] <= 3'h0;
                destPort[e] <= '0;
                destQueue[e] <= '0;
                groupTag[e] <= '0;
                interval[e] <= '0;
                remaining[e] <= '0;
            end
        end
        else
        begin
            if (svcRun)
            begin
                tickSeen[svcIdx] <= tickNow;
                remaining[svcIdx] <= next_remaining;
                if (inject && oneShot)
                    interval[svcIdx] <= '0;
            end
            if (tupeHit && tupeMisc[tis_pkg::TM_SET_TMR_ENA])
                timerEna[tupeAddr] <= tupeMisc[tis_pkg::TM_SET_TMR_VAL]; // RQ16
            if (tupeHit && tupeMisc[tis_pkg::TM_SET_PORT_ENA])
                destPort[tupeAddr] <= setPort; // RQ17
            if (tupeHit && tupeMisc[tis_pkg::TM_SET_QUEUE_ENA])
                destQueue[tupeAddr] <= setQueue; // RQ18
            if (wrD0)
            begin
                timerEna[tblIdx] <= regWdata[tis_pkg::D0_TMR_ENA];
                countEna[tblIdx] <= regWdata[tis_pkg::D0_CNT_ENA];
                tickSel[tblIdx] <= regWdata[tis_pkg::D0_TICK_LSB +: 3];
                destPort[tblIdx] <= regWdata[tis_pkg::D0_PORT_LSB +: tis_pkg::PORT_W];
                destQueue[tblIdx] <= regWdata[tis_pkg::D0_QUEUE_LSB +: tis_pkg::QUEUE_W];
                groupTag[tblIdx] <= regWdata[tis_pkg::D0_TAG_LSB +: tis_pkg::TAG_W];
            end
            if (wrD1)
            begin
                interval[tblIdx] <= regWdata[tis_pkg::LEN_W-1:0];
                remaining[tblIdx] <= regWdata[tis_pkg::D1_REM_LSB +: tis_pkg::LEN_W];
            end
        end
    end

    // ----------------------------------------------------------------
    // Update pass control
    // ----------------------------------------------------------------
    // A start while a pass runs restarts it from the first address
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tupeBusy <= 1'b0;
            tupeAddr <= '0;
        end
        else if (startReq)
        begin
            tupeAddr <= tupeStart; // RQ10
            tupeBusy <= tupeStart < tupeEnd; // RQ11
        end
        else if (tupeBusy)
        begin
            tupeAddr <= tupeNext;
            tupeBusy <= !tupeLast; // RQ23
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // The init bit is cleared on the same edge at which it acts; a new write wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrlEna <= 1'b0;
            ctrlInit <= 1'b0;
            calLen <= tis_pkg::CAL_LEN_RST;
        end
        else if (wrCtrl)
        begin
            ctrlEna <= regWdata[tis_pkg::CTRL_ENA];
            ctrlInit <= regWdata[tis_pkg::CTRL_INIT];
            calLen <= regWdata[tis_pkg::CTRL_LEN_LSB +: 2];
        end
        else
            ctrlInit <= 1'b0; // RQ7
    end

    // Pass criteria and commands; the start bit itself lives in tupeBusy
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tupeMisc <= 8'h00;
            tupeStart <= '0;
            tupeEnd <= '0;
            critPort <= '0;
            critQueue <= '0;
            critMask <= '0;
            critVal0 <= '0;
            critVal1 <= '0;
            setPort <= '0;
            setQueue <= '0;
            tblIdx <= '0;
        end
        else
        begin
            if (wrMisc)
                tupeMisc <= {regWdata[7:1], 1'b0};
            if (wrTupeAddr)
            begin
                tupeStart <= regWdata[tis_pkg::AW-1:0];
                tupeEnd <= regWdata[tis_pkg::HI_LSB +: tis_pkg::AW];
            end
            if (wrCrit1)
            begin
                critPort <= regWdata[tis_pkg::PORT_W-1:0];
                critQueue <= regWdata[tis_pkg::Q_LSB +: tis_pkg::QUEUE_W];
            end
            if (wrCrit2)
                critMask <= regWdata[tis_pkg::TAG_W-1:0];
            if (wrCrit3)
            begin
                critVal0 <= regWdata[tis_pkg::TAG_W-1:0];
                critVal1 <= regWdata[tis_pkg::Q_LSB +: tis_pkg::TAG_W];
            end
            if (wrCmd1)
            begin
                setPort <= regWdata[tis_pkg::PORT_W-1:0];
                setQueue <= regWdata[tis_pkg::Q_LSB +: tis_pkg::QUEUE_W];
            end
            if (wrIdx)
                tblIdx <= regWdata[tis_pkg::AW-1:0];
        end
    end

    // Calendar slot setup; reset values give one slot over the whole table
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int s = 0; s < tis_pkg::SLOTS; s++)
            begin
                slotFirst[s] <= tis_pkg::SLOT_FIRST_RST;
                slotLast[s] <= tis_pkg::SLOT_LAST_RST;
                slotCount[s] <= tis_pkg::CAL_SLOT_SERVICE_COUNT_RST;
            end
        end
        else
        begin
            if (wrPtrs)
            begin
                slotFirst[pageSlot] <= regWdata[tis_pkg::AW-1:0]; // RQ4
                slotLast[pageSlot] <= regWdata[tis_pkg::HI_LSB +: tis_pkg::AW];
            end
            if (wrCnt)
                slotCount[pageSlot] <= regWdata[tis_pkg::SCNT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Outputs and injection counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regRdata <= 32'h0;
            injValid <= 1'b0;
            injEntry <= '0;
            injPort <= '0;
            injQueue <= '0;
            injCount <= '0;
        end
        else
        begin
            regRdata <= regRd ? readMux : 32'h0;
            injValid <= inject;
            injEntry <= svcIdx;
            injPort <= destPort[svcIdx];
            injQueue <= destQueue[svcIdx];
            if (inject && countEna[svcIdx])
                injCount <= injCount + 32'h1; // RQ9
        end
    end
endmodule

/* src/tis_pkg.sv */
// Constants shared by the timed injection scheduler
package tis_pkg;
    // ----------------------------------------------------------------
    // Table and field sizes
    // ----------------------------------------------------------------
    localparam int ENTRIES = 2048;
    localparam int AW = 11;
    localparam int SLOTS = 4;
    localparam int PORT_W = 4;
    localparam int QUEUE_W = 8;
    localparam int TAG_W = 8;
    localparam int LEN_W = 8;
    localparam int SCNT_W = 12;
    localparam int ICNT_W = 32;
    localparam int BUS_AW = 8;
    localparam int SLOT_CYCLES = 1;
    localparam logic [LEN_W-1:0] LEN_ONESHOT = 8'hff;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [BUS_AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [BUS_AW-1:0] OFF_INJ_CNT = 8'h04;
    localparam logic [BUS_AW-1:0] OFF_TUPE_MISC = 8'h08;
    localparam logic [BUS_AW-1:0] OFF_TUPE_ADDR = 8'h0c;
    localparam logic [BUS_AW-1:0] OFF_CRIT1 = 8'h10;
    localparam logic [BUS_AW-1:0] OFF_CRIT2 = 8'h14;
    localparam logic [BUS_AW-1:0] OFF_CRIT3 = 8'h18;
    localparam logic [BUS_AW-1:0] OFF_CMD1 = 8'h1c;
    localparam logic [BUS_AW-1:0] OFF_TBL_IDX = 8'h20;
    localparam logic [BUS_AW-1:0] OFF_TBL_D0 = 8'h24;
    localparam logic [BUS_AW-1:0] OFF_TBL_D1 = 8'h28;
    localparam logic [3:0] PAGE_SLOT_PTRS = 4'h4;
    localparam logic [3:0] PAGE_CAL_SLOT_SERVICE_COUNT = 4'h5;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ENA = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_LEN_LSB = 4;
    localparam int TM_START = 0;
    localparam int TM_GRP_ENA = 1;
    localparam int TM_PORT_ENA = 2;
    localparam int TM_QUEUE_ENA = 3;
    localparam int TM_SET_TMR_ENA = 4;
    localparam int TM_SET_TMR_VAL = 5;
    localparam int TM_SET_PORT_ENA = 6;
    localparam int TM_SET_QUEUE_ENA = 7;
    localparam int HI_LSB = 16;
    localparam int Q_LSB = 8;
    localparam int D0_TMR_ENA = 0;
    localparam int D0_CNT_ENA = 1;
    localparam int D0_TICK_LSB = 2;
    localparam int D0_PORT_LSB = 8;
    localparam int D0_QUEUE_LSB = 16;
    localparam int D0_TAG_LSB = 24;
    localparam int D1_REM_LSB = 8;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] SLOT_FIRST_RST = 11'h000;
    localparam logic [AW-1:0] SLOT_LAST_RST = 11'h7ff;
    localparam logic [SCNT_W-1:0] CAL_SLOT_SERVICE_COUNT_RST = 12'h001;
    localparam logic [1:0] CAL_LEN_RST = 2'h0;
endpackage

/* testbench/tis_scheduler_monitor.sv */
// Port-level checker for the timed injection scheduler
module tis_scheduler_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [tis_pkg::BUS_AW-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic injValid,
    input wire logic [tis_pkg::AW-1:0] injEntry
);
    timeunit 1ns;
    timeprecision 1ps;
    logic enSeen;
    logic rdCnt;
    logic [31:0] lastCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Track software enable and the last counter value read back
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enSeen <= 1'b0;
            rdCnt <= 1'b0;
            lastCnt <= 32'h0;
        end
        else
        begin
            if (regWr && regAddr == tis_pkg::OFF_CTRL)
                enSeen <= regWdata[tis_pkg::CTRL_ENA];
            rdCnt <= regRd && regAddr == tis_pkg::OFF_INJ_CNT;
            if (rdCnt)
                lastCnt <= regRdata;
        end
    end

    sequence sInit;
        regWr && regAddr == tis_pkg::OFF_CTRL && regWdata[tis_pkg::CTRL_INIT] ##1 !regWr [*2]
            ##1 regRd && regAddr == tis_pkg::OFF_CTRL;
    endsequence
    sequence sSlotWrRd;
        (regWr && regAddr[7:4] == tis_pkg::PAGE_SLOT_PTRS) ##1 (regRd && regAddr == $past(regAddr));
    endsequence
    sequence sIdxWrRd;
        (regWr && regAddr == tis_pkg::OFF_TBL_IDX) ##1 (regRd && regAddr == tis_pkg::OFF_TBL_IDX);
    endsequence

    AST_RD_IDLE_ZERO: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("stray read data");
    AST_UNMAPPED_ZERO: assert property (regRd && regAddr == 8'h30 |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    AST_INIT_SELF_CLEAR: assert property (sInit |=> !regRdata[tis_pkg::CTRL_INIT])
        else $error("init bit did not clear");
    AST_SLOT_PTR_RDBACK: assert property (sSlotWrRd |=>
        (regRdata & 32'h07ff07ff) == ($past(regWdata, 2) & 32'h07ff07ff))
        else $error("slot pointers not read back");
    AST_TBL_IDX_RDBACK: assert property (sIdxWrRd |=>
        (regRdata & 32'h7ff) == ($past(regWdata, 2) & 32'h7ff))
        else $error("table index not read back");
    AST_INJ_NEEDS_ENABLE: assert property (injValid |-> enSeen || $past(enSeen))
        else $error("injection while disabled");
    AST_INJ_COUNT_MONO: assert property (rdCnt |-> regRdata >= lastCnt)
        else $error("count went down");
    AST_INJ_ENTRY_ADVANCE: assert property (injValid ##1 injValid |-> injEntry != $past(injEntry))
        else $error("entry injected twice");
endmodule

bind tis_scheduler tis_scheduler_monitor i_tis_scheduler_monitor (.clk(clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .injValid(injValid), .injEntry(injEntry));

/* testbench/tb.sv */
// Self-checking bench for the timed injection scheduler
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic arst_n;
    logic [tis_pkg::BUS_AW-1:0] regAddr;
    logic [31:0] regWdata;
    logic regWr;
    logic regRd;
    logic [31:0] regRdata;
    logic [7:0] tickToggle;
    logic injValid;
    logic [tis_pkg::AW-1:0] injEntry;
    logic [tis_pkg::PORT_W-1:0] injPort;
    logic [tis_pkg::QUEUE_W-1:0] injQueue;
    int miscompares;
    int samples_checked;
    int cycles;
    logic [31:0] d;
    logic [7:0] tags [6] = '{8'h03, 8'h23, 8'ha5, 8'h03, 8'h04, 8'h03};
    logic [3:0] ports [6] = '{4'h2, 4'h2, 4'h2, 4'h1, 4'h2, 4'h2};

    tis_scheduler i_tis_scheduler (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .tickToggle(tickToggle), .injValid(injValid), .injEntry(injEntry),
        .injPort(injPort), .injQueue(injQueue));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    // Strobe stays high so writes may run back to back
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regRd <= 1'b0;
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
    endtask
    task automatic idle();
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(d, exp);
    endtask
    function automatic logic [31:0] ent(logic [7:0] t, logic [7:0] q, logic [3:0] p, logic e);
        return {t, q, 4'h0, p, 7'h0, e};
    endfunction
    task automatic set_ent(input int i, input logic [31:0] d0, input logic [31:0] d1);
        wr(tis_pkg::OFF_TBL_IDX, 32'(i));
        wr(tis_pkg::OFF_TBL_D0, d0);
        wr(tis_pkg::OFF_TBL_D1, d1);
    endtask
    // Busy seen once, then must drop
    task automatic wait_done();
        rd(tis_pkg::OFF_TUPE_MISC, d);
        chk({31'h0, d[0]}, 32'h1);
        for (int n = 0; n < 20 && d[0] !== 1'b0; n++)
            rd(tis_pkg::OFF_TUPE_MISC, d);
        chk({31'h0, d[0]}, 32'h0);
    endtask
    task automatic close_out();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_regs();
        rdchk(8'h40, 32'h07ff0000);
        rdchk(8'h50, 32'h00000001);
        rdchk(tis_pkg::OFF_CTRL, 32'h0);
        rdchk(tis_pkg::OFF_INJ_CNT, 32'h0);
        rdchk(8'h30, 32'h0);
        wr(8'h4c, 32'h01230045);
        rdchk(8'h4c, 32'h01230045);
        wr(8'h4c, 32'h07ff0000);
        wr(tis_pkg::OFF_TBL_IDX, 32'h5);
        rdchk(tis_pkg::OFF_TBL_IDX, 32'h5);
        wr(tis_pkg::OFF_CTRL, 32'h2);
        idle();
        idle();
        rdchk(tis_pkg::OFF_CTRL, 32'h0);
    endtask
    // Group and port pass, then a queue-only pass
    task automatic t_update();
        for (int i = 0; i < 6; i++)
            set_ent(i, ent(tags[i], 8'h11, ports[i], 1'b0), 32'h0);
        wr(tis_pkg::OFF_CRIT1, 32'h4402);
        wr(tis_pkg::OFF_CRIT2, 32'h0f);
        wr(tis_pkg::OFF_CRIT3, 32'h0503);
        wr(tis_pkg::OFF_CMD1, 32'h4407);
        wr(tis_pkg::OFF_TUPE_ADDR, 32'h00050001);
        wr(tis_pkg::OFF_TUPE_MISC, 32'hf7);
        wait_done();
        for (int i = 0; i < 6; i++)
        begin
            wr(tis_pkg::OFF_TBL_IDX, 32'(i));
            rd(tis_pkg::OFF_TBL_D0, d);
            chk(d, (i == 1 || i == 2) ? ent(tags[i], 8'h44, 4'h7, 1'b1)
                : ent(tags[i], 8'h11, ports[i], 1'b0));
        end
        wr(tis_pkg::OFF_CRIT2, 32'h0);
        wr(tis_pkg::OFF_CMD1, 32'h5507);
        wr(tis_pkg::OFF_TUPE_ADDR, 32'h00060000);
        wr(tis_pkg::OFF_TUPE_MISC, 32'h89);
        wait_done();
        for (int i = 0; i < 6; i++)
        begin
            wr(tis_pkg::OFF_TBL_IDX, 32'(i));
            rd(tis_pkg::OFF_TBL_D0, d);
            chk(d, (i == 1 || i == 2) ? ent(tags[i], 8'h55, 4'h7, 1'b1)
                : ent(tags[i], 8'h11, ports[i], 1'b0));
        end
    endtask
    // One-shot entry fires once, then is disarmed
    task automatic t_inject();
        int extra = 0;
        set_ent(7, 32'h002a0303, 32'h000000ff);
        wr(tis_pkg::OFF_CTRL, 32'h2);
        wr(tis_pkg::OFF_CTRL, 32'h1);
        idle();
        for (int n = 0; n < 32 && injValid !== 1'b1; n++)
            @(posedge clk) #1;
        chk({9'h0, injEntry, injPort, injQueue}, 32'h732a);
        repeat (2100)
        begin
            @(posedge clk) #1;
            if (injValid !== 1'b0)
                extra++;
        end
        chk(32'(extra), 32'h0);
        rdchk(tis_pkg::OFF_INJ_CNT, 32'h1);
        wr(tis_pkg::OFF_TBL_IDX, 32'h7);
        rd(tis_pkg::OFF_TBL_D1, d);
        chk(d & 32'hff, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Run takes about 2.2k cycles; 10k leaves margin
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            miscompares++;
            close_out();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        regAddr = 8'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        tickToggle = 8'h0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_regs();
        t_update();
        t_inject();
        idle();
        close_out();
    end
endmodule
